// ---- rtl/pll_bandwidth_divider_control.sv ----
// Design: APB register block for PLL bandwidth, multiplier, range and divider control
`default_nettype none

// How it works
// [RULE_01] Auto bit picks automatic or manual bandwidth
// [RULE_02] Settled reads live lock only in auto
// [RULE_03] Software always writes settled position as zero
// [RULE_04] Acquisition bit: status in auto, control manually
// [RULE_05] Manual acquisition value kept during auto mode
// [RULE_06] Reset: manual mode, acquisition, not settled
// [RULE_07] Software clears acquisition before turning PLL on
// [RULE_08] Twelve-bit multiplier; zero behaves as one
// [RULE_09] Multiplier resets to hex forty
// [RULE_10] Multiplier writes ignored while PLL on
// [RULE_11] Eight-bit VCO range, resets to hex forty
// [RULE_12] Range writes ignored while PLL on
// [RULE_13] Zero range disables PLL, blocks base select
// [RULE_14] Four-bit reference divider; zero as one; reset one
// [RULE_15] Divider writes ignored while PLL on
// [RULE_16] Each settle change sets flag; enable gates interrupt
// [RULE_17] Manual mode: no interrupt, flag reads zero
// [RULE_18] Software checks settled state after interrupt
// [RULE_19] Base select allowed even when not settled
// [RULE_20] Wait changes nothing; stop powers PLL down
// [RULE_21] Software clears base select before stop
// [RULE_22] Break with clear-enable low protects flag
// [RULE_23] Control register read clears the flag
// [RULE_24] PLL-on and base-select protect each other
// [RULE_25] Manual mode: interrupt enable ignores writes, reads zero
// [RULE_26] Lock input synchronised before change detection
module pll_bandwidth_divider_control (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Analog loop status
   input  wire logic        LOCK_DETECT,
   input  wire logic        LOOP_TRACKING,
   // System modes
   input  wire logic        STOP_MODE,
   input  wire logic        WAIT_MODE,
   input  wire logic        BREAK_STATE,
   input  wire logic        BREAK_CLEAR_ENABLE,
   // Loop configuration
   output logic             PLL_ENABLE,
   output logic             BASE_CLOCK_SELECT,
   output logic             AUTO_BANDWIDTH,
   output logic             MANUAL_TRACKING,
   output logic [11:0]      FEEDBACK_MODULUS,
   output logic [7:0]       VCO_RANGE,
   output logic [3:0]       REFERENCE_DIVISOR,
   output logic [1:0]       PRESCALER_SELECT,
   output logic [1:0]       POWER_EXPONENT,
   // Interrupt
   output logic             PLL_INTERRUPT_REQUEST
);
   import pll_ctrl_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      apb_phase_t  phase;
      logic [31:0] rdata;
      logic        auto_mode;
      logic        acq_manual;
      logic        irq_enable;
      logic        change_flag;
      logic        power_on;
      logic        base_select;
      logic [1:0]  prescaler;
      logic [1:0]  exponent;
      logic [11:0] multiplier;
      logic [7:0]  vco_range;
      logic [3:0]  ref_divider;
      logic        lock_meta;
      logic        lock_sync;
      logic        lock_prev;
      logic        track_meta;
      logic        track_sync;
      logic        pll_run;
      logic [11:0] modulus;
      logic [3:0]  divisor;
   } state_t;

   localparam state_t RESET_STATE = '{
      phase:       PH_IDLE,
      rdata:       32'h0000_0000,
      auto_mode:   1'b0,
      acq_manual:  1'b0,
      irq_enable:  1'b0,
      change_flag: 1'b0,
      power_on:    RST_PLL_ON,
      base_select: 1'b0,
      prescaler:   2'h0,
      exponent:    2'h0,
      multiplier:  RST_MULTIPLIER,
      vco_range:   RST_VCO_RANGE,
      ref_divider: RST_REF_DIVIDER,
      lock_meta:   1'b0,
      lock_sync:   1'b0,
      lock_prev:   1'b0,
      track_meta:  1'b0,
      track_sync:  1'b0,
      pll_run:     1'b0,
      modulus:     RST_MULTIPLIER,
      divisor:     RST_REF_DIVIDER
   };

   state_t st_reg;
   state_t st_next;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == OFF_PLL_CONTROL) || (addr == OFF_BANDWIDTH) ||
                  (addr == OFF_MULTIPLIER_HIGH) || (addr == OFF_MULTIPLIER_LOW) ||
                  (addr == OFF_VCO_RANGE) || (addr == OFF_REFERENCE_DIV);
   endfunction

   function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
      hits = (addr == off);
   endfunction

   logic access;
   logic wr_take;
   logic rd_capture;
   logic lock_change;
   logic clear_allowed;
   logic [7:0] ctl_view;
   logic [7:0] bw_view;
   logic [7:0] wbyte;

   assign access        = PSEL && PENABLE;
   assign wr_take       = access && PWRITE;
   assign rd_capture    = access && !PWRITE && (st_reg.phase == PH_IDLE);
   assign lock_change   = st_reg.auto_mode && (st_reg.lock_sync != st_reg.lock_prev);  // RULE_16
   assign clear_allowed = !BREAK_STATE || BREAK_CLEAR_ENABLE;                          // RULE_22
   assign wbyte         = PWDATA[7:0];

   // ****************************************
   // Read views
   // ****************************************
   always_comb begin
      ctl_view = 8'h00;
      ctl_view[CTL_IE_BIT]   = st_reg.irq_enable && st_reg.auto_mode;              // RULE_25
      ctl_view[CTL_FLAG_BIT] = st_reg.change_flag && st_reg.auto_mode;             // RULE_17
      ctl_view[CTL_ON_BIT]   = st_reg.power_on;
      ctl_view[CTL_BCS_BIT]  = st_reg.base_select;
      ctl_view[CTL_PRE_LSB +: 2] = st_reg.prescaler;
      ctl_view[CTL_VPR_LSB +: 2] = st_reg.exponent;
      bw_view = 8'h00;
      bw_view[BW_AUTO_BIT]    = st_reg.auto_mode;
      bw_view[BW_SETTLED_BIT] = st_reg.auto_mode && st_reg.lock_sync;              // RULE_02
      bw_view[BW_ACQ_BIT]     = st_reg.auto_mode ? st_reg.track_sync : st_reg.acq_manual;  // RULE_04
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_next = st_reg;

      // Synchronisers and change detection
      st_next.lock_meta  = LOCK_DETECT;                       // RULE_26
      st_next.lock_sync  = st_reg.lock_meta;                  // RULE_26
      st_next.lock_prev  = st_reg.lock_sync;
      st_next.track_meta = LOOP_TRACKING;
      st_next.track_sync = st_reg.track_meta;

      // Read phase: one wait state, data captured from flops
      if (rd_capture) begin
         st_next.phase = PH_HOLD;
         case (PADDR)
            OFF_PLL_CONTROL:     st_next.rdata = {24'h0, ctl_view};
            OFF_BANDWIDTH:       st_next.rdata = {24'h0, bw_view};
            OFF_MULTIPLIER_HIGH: st_next.rdata = {28'h0, st_reg.multiplier[11:8]};
            OFF_MULTIPLIER_LOW:  st_next.rdata = {24'h0, st_reg.multiplier[7:0]};
            OFF_VCO_RANGE:       st_next.rdata = {24'h0, st_reg.vco_range};
            OFF_REFERENCE_DIV:   st_next.rdata = {28'h0, st_reg.ref_divider};
            default:             st_next.rdata = 32'h0000_0000;
         endcase
         if (hits(PADDR, OFF_PLL_CONTROL) && clear_allowed) begin
            st_next.change_flag = 1'b0;                       // RULE_23 RULE_22
         end
      end else if (st_reg.phase == PH_HOLD) begin
         st_next.phase = PH_IDLE;
      end else begin
         st_next.phase = PH_IDLE;
      end

      // Register writes
      if (wr_take) begin
         case (PADDR)
            OFF_PLL_CONTROL: begin
               if (st_reg.auto_mode) begin
                  st_next.irq_enable = wbyte[CTL_IE_BIT];      // RULE_25
               end
               // A combined write must not leave base select up with the PLL off
               if (wbyte[CTL_ON_BIT] || (!st_reg.base_select && !wbyte[CTL_BCS_BIT])) begin
                  st_next.power_on = wbyte[CTL_ON_BIT];        // RULE_24
               end
               if (!wbyte[CTL_BCS_BIT] || st_reg.power_on) begin
                  st_next.base_select = wbyte[CTL_BCS_BIT];    // RULE_24 RULE_19
               end
               if (!st_reg.power_on) begin
                  st_next.prescaler = wbyte[CTL_PRE_LSB +: 2];
                  st_next.exponent  = wbyte[CTL_VPR_LSB +: 2];
               end
            end
            OFF_BANDWIDTH: begin
               st_next.auto_mode = wbyte[BW_AUTO_BIT];          // RULE_01
               if (!st_reg.auto_mode) begin
                  st_next.acq_manual = wbyte[BW_ACQ_BIT];       // RULE_04 RULE_05
               end
            end
            OFF_MULTIPLIER_HIGH: begin
               if (!st_reg.power_on) begin
                  st_next.multiplier[11:8] = wbyte[3:0];        // RULE_10
               end
            end
            OFF_MULTIPLIER_LOW: begin
               if (!st_reg.power_on) begin
                  st_next.multiplier[7:0] = wbyte;              // RULE_10
               end
            end
            OFF_VCO_RANGE: begin
               if (!st_reg.power_on) begin
                  st_next.vco_range = wbyte;                    // RULE_12
               end
            end
            OFF_REFERENCE_DIV: begin
               if (!st_reg.power_on) begin
                  st_next.ref_divider = wbyte[3:0];             // RULE_15
               end
            end
            default: begin
               st_next.rdata = st_reg.rdata;
            end
         endcase
      end

      // Zero range forbids the VCO as base clock
      if (st_next.vco_range == 8'h00) begin
         st_next.base_select = 1'b0;                            // RULE_13
      end

      // Flag: set wins over a clear in the same cycle
      if (lock_change) begin
         st_next.change_flag = 1'b1;                            // RULE_16
      end
      if (!st_reg.auto_mode) begin
         st_next.change_flag = 1'b0;                            // RULE_17
      end

      // Loop runs only when on, range valid and not stopped; wait has no effect
      st_next.pll_run = st_next.power_on && (st_next.vco_range != 8'h00) && !STOP_MODE;  // RULE_20 RULE_13

      // Effective moduli
      st_next.modulus = (st_next.multiplier == 12'h000) ? MIN_MODULUS : st_next.multiplier;     // RULE_08
      st_next.divisor = (st_next.ref_divider == 4'h0) ? MIN_REF_DIVIDER : st_next.ref_divider;  // RULE_14
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_reg <= RESET_STATE;                                 // RULE_06 RULE_09 RULE_11 RULE_14
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign PREADY                = access && (PWRITE || (st_reg.phase == PH_HOLD));
   assign PSLVERR               = PREADY && !is_mapped(PADDR);
   assign PRDATA                = st_reg.rdata;
   assign PLL_ENABLE            = st_reg.pll_run;
   assign BASE_CLOCK_SELECT     = st_reg.base_select;
   assign AUTO_BANDWIDTH        = st_reg.auto_mode;
   assign MANUAL_TRACKING       = st_reg.acq_manual;
   assign FEEDBACK_MODULUS      = st_reg.modulus;
   assign VCO_RANGE             = st_reg.vco_range;
   assign REFERENCE_DIVISOR     = st_reg.divisor;
   assign PRESCALER_SELECT      = st_reg.prescaler;
   assign POWER_EXPONENT        = st_reg.exponent;
   assign PLL_INTERRUPT_REQUEST = st_reg.change_flag && st_reg.irq_enable && st_reg.auto_mode;  // RULE_16 RULE_17

   // ****************************************
   // Assertions
   // ****************************************
   a_change_sets_flag: assert property (@(posedge CLK) disable iff (RESET) // RULE_16
      lock_change |=> st_reg.change_flag)
      else $error("settle change did not set flag");

   a_manual_no_irq: assert property (@(posedge CLK) disable iff (RESET) // RULE_17
      !st_reg.auto_mode |-> !PLL_INTERRUPT_REQUEST)
      else $error("interrupt raised in manual mode");

   a_irq_needs_enable: assert property (@(posedge CLK) disable iff (RESET) // RULE_16
      $rose(PLL_INTERRUPT_REQUEST) |-> st_reg.irq_enable && st_reg.change_flag)
      else $error("interrupt without enable and flag");

   a_read_clears_flag: assert property (@(posedge CLK) disable iff (RESET) // RULE_23
      rd_capture && hits(PADDR, OFF_PLL_CONTROL) && clear_allowed && !lock_change |=> !st_reg.change_flag)
      else $error("control read did not clear flag");

   a_break_keeps_flag: assert property (@(posedge CLK) disable iff (RESET) // RULE_22
      rd_capture && BREAK_STATE && !BREAK_CLEAR_ENABLE && st_reg.change_flag && st_reg.auto_mode
      |=> st_reg.change_flag)
      else $error("flag lost during protected break");

   a_mul_locked: assert property (@(posedge CLK) disable iff (RESET) // RULE_10
      st_reg.power_on |=> $stable(st_reg.multiplier))
      else $error("multiplier changed while PLL on");

   a_range_locked: assert property (@(posedge CLK) disable iff (RESET) // RULE_12
      st_reg.power_on |=> $stable(st_reg.vco_range))
      else $error("range changed while PLL on");

   a_divider_locked: assert property (@(posedge CLK) disable iff (RESET) // RULE_15
      st_reg.power_on |=> $stable(st_reg.ref_divider))
      else $error("divider changed while PLL on");

   a_zero_range_bcs: assert property (@(posedge CLK) disable iff (RESET) // RULE_13
      (st_reg.vco_range == 8'h00) |-> !BASE_CLOCK_SELECT && !PLL_ENABLE)
      else $error("zero range left base select or PLL on");

   a_on_held_by_bcs: assert property (@(posedge CLK) disable iff (RESET) // RULE_24
      st_reg.base_select |=> st_reg.power_on)
      else $error("PLL turned off under base select");

   a_bcs_needs_on: assert property (@(posedge CLK) disable iff (RESET) // RULE_24
      !st_reg.power_on |=> !st_reg.base_select)
      else $error("base select set while PLL off");

   a_shadow_kept: assert property (@(posedge CLK) disable iff (RESET) // RULE_05
      st_reg.auto_mode |=> $stable(st_reg.acq_manual))
      else $error("manual acquisition changed in auto");

   a_stop_powers_down: assert property (@(posedge CLK) disable iff (RESET) // RULE_20
      STOP_MODE |=> !PLL_ENABLE)
      else $error("PLL running in stop");

   a_modulus_min: assert property (@(posedge CLK) disable iff (RESET) // RULE_08
      (FEEDBACK_MODULUS != 12'h000) && (REFERENCE_DIVISOR != 4'h0))
      else $error("zero modulus reached output");

   a_settled_manual: assert property (@(posedge CLK) disable iff (RESET) // RULE_02
      rd_capture && hits(PADDR, OFF_BANDWIDTH) && !st_reg.auto_mode |=> !PRDATA[BW_SETTLED_BIT])
      else $error("settled read non-zero in manual");

   a_ie_manual_zero: assert property (@(posedge CLK) disable iff (RESET) // RULE_25
      rd_capture && hits(PADDR, OFF_PLL_CONTROL) && !st_reg.auto_mode
      |=> !PRDATA[CTL_IE_BIT] && !PRDATA[CTL_FLAG_BIT])
      else $error("enable or flag read non-zero in manual");

endmodule
`default_nettype wire

// ---- common/pll_ctrl_pkg.sv ----
// Package: register map, field positions and reset values of the PLL control block
`default_nettype none
package pll_ctrl_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_PLL_CONTROL      = 8'h00;
   localparam logic [7:0] OFF_BANDWIDTH        = 8'h04;
   localparam logic [7:0] OFF_MULTIPLIER_HIGH  = 8'h08;
   localparam logic [7:0] OFF_MULTIPLIER_LOW   = 8'h0c;
   localparam logic [7:0] OFF_VCO_RANGE        = 8'h10;
   localparam logic [7:0] OFF_REFERENCE_DIV    = 8'h14;

   // ****************************************
   // Control register fields
   // ****************************************
   localparam int CTL_IE_BIT   = 7;
   localparam int CTL_FLAG_BIT = 6;
   localparam int CTL_ON_BIT   = 5;
   localparam int CTL_BCS_BIT  = 4;
   localparam int CTL_PRE_LSB  = 2;
   localparam int CTL_VPR_LSB  = 0;

   // ****************************************
   // Bandwidth register fields
   // ****************************************
   localparam int BW_AUTO_BIT    = 7;
   localparam int BW_SETTLED_BIT = 6;
   localparam int BW_ACQ_BIT     = 5;

   // ****************************************
   // Reset values and substitutes for a zero modulus or divider
   // ****************************************
   localparam logic        RST_PLL_ON       = 1'b1;
   localparam logic [11:0] RST_MULTIPLIER   = 12'h040;
   localparam logic [7:0]  RST_VCO_RANGE    = 8'h40;
   localparam logic [3:0]  RST_REF_DIVIDER  = 4'h1;
   localparam logic [11:0] MIN_MODULUS      = 12'h001;
   localparam logic [3:0]  MIN_REF_DIVIDER  = 4'h1;

   // ****************************************
   // Bus phase of a read
   // ****************************************
   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_HOLD = 2'b10
   } apb_phase_t;

endpackage
`default_nettype wire

// ---- testbench/pll_bandwidth_divider_control_test.sv ----
// Testbench: self-checking APB stimulus for the PLL bandwidth and divider control block
`default_nettype none
module pll_bandwidth_divider_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   import pll_ctrl_pkg::*;

   // ****************************************
   // Signals
   // ****************************************
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        lock = 1'b0;
   logic        tracking = 1'b0;
   logic        stop_mode = 1'b0;
   logic        wait_mode = 1'b0;
   logic        brk = 1'b0;
   logic        brk_clr = 1'b0;
   logic        pll_en;
   logic        base_clock_select_bit;
   logic        auto_bw;
   logic        man_trk;
   logic [11:0] modulus;
   logic [7:0]  range;
   logic [3:0]  divisor;
   logic [1:0]  prescaler;
   logic [1:0]  exponent;
   logic        irq;
   logic [31:0] rdata;
   logic        rerr;
   int          num_errors = 0;
   int          n_tests = 0;
   integer      seed = 32'h065a;
   logic [7:0]  h;
   logic [7:0]  l;
   logic [7:0]  r;
   logic [7:0]  d;

   always #25 clk = ~clk;

   pll_bandwidth_divider_control dut (
      .CLK                   (clk),
      .RESET                 (reset),
      .PSEL                  (psel),
      .PENABLE               (penable),
      .PWRITE                (pwrite),
      .PADDR                 (paddr),
      .PWDATA                (pwdata),
      .PRDATA                (prdata),
      .PREADY                (pready),
      .PSLVERR               (pslverr),
      .LOCK_DETECT           (lock),
      .LOOP_TRACKING         (tracking),
      .STOP_MODE             (stop_mode),
      .WAIT_MODE             (wait_mode),
      .BREAK_STATE           (brk),
      .BREAK_CLEAR_ENABLE    (brk_clr),
      .PLL_ENABLE            (pll_en),
      .BASE_CLOCK_SELECT     (base_clock_select_bit),
      .AUTO_BANDWIDTH        (auto_bw),
      .MANUAL_TRACKING       (man_trk),
      .FEEDBACK_MODULUS      (modulus),
      .VCO_RANGE             (range),
      .REFERENCE_DIVISOR     (divisor),
      .PRESCALER_SELECT      (prescaler),
      .POWER_EXPONENT        (exponent),
      .PLL_INTERRUPT_REQUEST (irq)
   );

   // ****************************************
   // Tasks
   // ****************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits for PREADY with no limit of its own
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(name, rdata, {24'h0, exp});
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask

   function automatic logic [11:0] fold_mod(input logic [11:0] m);
      return (m == 12'h000) ? 12'h001 : m;
   endfunction

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      check("modulus", {20'h0, modulus}, 32'h40);
      check("range", {24'h0, range}, 32'h40);
      check("divisor", {28'h0, divisor}, 32'h1);
      check("auto", {31'h0, auto_bw}, 32'h0);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h20);
      check("enable", {31'h0, pll_en}, 32'h1);
      rd_chk("bw", OFF_BANDWIDTH, 8'h00);
      rd_chk("mulh", OFF_MULTIPLIER_HIGH, 8'h00);
      rd_chk("mull", OFF_MULTIPLIER_LOW, 8'h40);
      rd_chk("rng", OFF_VCO_RANGE, 8'h40);
      rd_chk("div", OFF_REFERENCE_DIV, 8'h01);
      $display("test reset done");
      apb(1'b1, OFF_MULTIPLIER_HIGH, 8'h0f);
      apb(1'b1, OFF_MULTIPLIER_LOW, 8'h12);
      apb(1'b1, OFF_VCO_RANGE, 8'h33);
      apb(1'b1, OFF_REFERENCE_DIV, 8'h07);
      apb(1'b1, OFF_PLL_CONTROL, 8'h2f);
      check("modulus", {20'h0, modulus}, 32'h40);
      check("range", {24'h0, range}, 32'h40);
      check("divisor", {28'h0, divisor}, 32'h1);
      check("prescaler", {30'h0, prescaler}, 32'h0);
      $display("test protection done");
      apb(1'b1, OFF_PLL_CONTROL, 8'h00);
      check("enable", {31'h0, pll_en}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         h = (i == 0) ? 8'h00 : 8'($random(seed));
         l = (i == 0) ? 8'h00 : 8'($random(seed));
         r = 8'($random(seed));
         d = (i == 0) ? 8'h00 : 8'($random(seed));
         apb(1'b1, OFF_MULTIPLIER_HIGH, h);
         apb(1'b1, OFF_MULTIPLIER_LOW, l);
         apb(1'b1, OFF_VCO_RANGE, r);
         apb(1'b1, OFF_REFERENCE_DIV, d);
         check("modulus", {20'h0, modulus}, {20'h0, fold_mod({h[3:0], l})});
         check("range", {24'h0, range}, {24'h0, r});
         check("divisor", {28'h0, divisor}, {28'h0, (d[3:0] == 4'h0) ? 4'h1 : d[3:0]});
         rd_chk("mull", OFF_MULTIPLIER_LOW, l);
      end
      apb(1'b1, OFF_PLL_CONTROL, 8'h0e);
      check("prescaler", {30'h0, prescaler}, 32'h3);
      check("exponent", {30'h0, exponent}, 32'h2);
      $display("test dividers done");
      apb(1'b1, OFF_VCO_RANGE, 8'h00);
      apb(1'b1, OFF_PLL_CONTROL, 8'h2e);
      apb(1'b1, OFF_PLL_CONTROL, 8'h3e);
      check("enable", {31'h0, pll_en}, 32'h0);
      check("bcs", {31'h0, base_clock_select_bit}, 32'h0);
      apb(1'b1, OFF_PLL_CONTROL, 8'h0e);
      apb(1'b1, OFF_VCO_RANGE, 8'h55);
      apb(1'b1, OFF_PLL_CONTROL, 8'h1e);
      check("bcs", {31'h0, base_clock_select_bit}, 32'h0);
      apb(1'b1, OFF_PLL_CONTROL, 8'h2e);
      apb(1'b1, OFF_PLL_CONTROL, 8'h3e);
      check("bcs", {31'h0, base_clock_select_bit}, 32'h1);
      apb(1'b1, OFF_PLL_CONTROL, 8'h1e);
      check("enable", {31'h0, pll_en}, 32'h1);
      check("bcs", {31'h0, base_clock_select_bit}, 32'h1);
      apb(1'b1, OFF_PLL_CONTROL, 8'h2e);
      apb(1'b1, OFF_PLL_CONTROL, 8'h1e);
      check("enable", {31'h0, pll_en}, 32'h1);
      check("bcs", {31'h0, base_clock_select_bit}, 32'h1);
      apb(1'b1, OFF_PLL_CONTROL, 8'h2e);
      $display("test clock select done");
      @(posedge clk);
      wait_mode <= 1'b1;
      cyc(4);
      check("enable", {31'h0, pll_en}, 32'h1);
      @(posedge clk);
      stop_mode <= 1'b1;
      cyc(2);
      check("enable", {31'h0, pll_en}, 32'h0);
      @(posedge clk);
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
      cyc(2);
      check("enable", {31'h0, pll_en}, 32'h1);
      $display("test modes done");
      apb(1'b1, OFF_BANDWIDTH, 8'h20);
      check("trk", {31'h0, man_trk}, 32'h1);
      apb(1'b1, OFF_PLL_CONTROL, 8'hae);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h2e);
      @(posedge clk);
      lock <= 1'b1;
      cyc(6);
      check("irq", {31'h0, irq}, 32'h0);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h2e);
      rd_chk("bw", OFF_BANDWIDTH, 8'h20);
      @(posedge clk);
      lock <= 1'b0;
      tracking <= 1'b1;
      cyc(6);
      apb(1'b1, OFF_BANDWIDTH, 8'ha0);
      apb(1'b1, OFF_BANDWIDTH, 8'h80);
      check("auto", {31'h0, auto_bw}, 32'h1);
      check("trk", {31'h0, man_trk}, 32'h1);
      rd_chk("bw", OFF_BANDWIDTH, 8'ha0);
      apb(1'b1, OFF_PLL_CONTROL, 8'hae);
      @(posedge clk);
      lock <= 1'b1;
      cyc(6);
      check("irq", {31'h0, irq}, 32'h1);
      rd_chk("bw", OFF_BANDWIDTH, 8'he0);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'hee);
      check("irq", {31'h0, irq}, 32'h0);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'hae);
      apb(1'b1, OFF_PLL_CONTROL, 8'h2e);
      @(posedge clk);
      lock <= 1'b0;
      cyc(6);
      check("irq", {31'h0, irq}, 32'h0);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h6e);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h2e);
      @(posedge clk);
      brk <= 1'b1;
      lock <= 1'b1;
      cyc(6);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h6e);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h6e);
      @(posedge clk);
      brk_clr <= 1'b1;
      cyc(1);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h6e);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h2e);
      @(posedge clk);
      brk <= 1'b0;
      lock <= 1'b0;
      cyc(6);
      apb(1'b1, OFF_BANDWIDTH, 8'h00);
      check("auto", {31'h0, auto_bw}, 32'h0);
      rd_chk("ctl", OFF_PLL_CONTROL, 8'h2e);
      check("irq", {31'h0, irq}, 32'h0);
      $display("test bandwidth done");
      apb(1'b0, 8'h18, 8'h00);
      check("err", {31'h0, rerr}, 32'h1);
      check("unmapped", rdata, 32'h0);
      apb(1'b1, 8'h1c, 8'hff);
      check("err", {31'h0, rerr}, 32'h1);
      $display("test unmapped done");
      report_and_stop();
   end
endmodule
`default_nettype wire
